/* src/ssc_ahb_port.sv */
// one ahb slave front end of the shared sram controller
`timescale 1ns/1ps
`default_nettype none
`include "ssc_params.svh"
module ssc_ahb_port (
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      reset_n_i,
  // ahb slave
  input  wire logic                      hsel_i,
  input  wire logic [`SSC_ADDR_W-1:0]    haddr_i,
  input  wire logic [1:0]                htrans_i,
  input  wire logic                      hwrite_i,
  input  wire logic [2:0]                hsize_i,
  input  wire logic                      hready_i,
  input  wire logic [`SSC_DATA_W-1:0]    hwdata_i,
  output logic                           hreadyout_o,
  output logic                           hresp_o,
  // towards the storage core
  output logic                           pend_o,
  output logic [`SSC_IDX_W-1:0]          idx_o,
  input  wire logic                      grant_i,
  output logic                           wr_o,
  output logic                           rd_o,
  output logic [`SSC_BE_W-1:0]           be_o,
  output logic [`SSC_DATA_W-1:0]         wdata_o
);
  ssc_pkg::ssc_port_state_e state_q;
  logic [`SSC_ADDR_W-1:0] addr_q;
  logic [2:0]             size_q;
  logic                   write_q;
  logic                   accept;

  // address phase taken on nonseq or seq with bus ready
  assign accept = hsel_i & hready_i & htrans_i[`SSC_HTRANS_SEQ_BIT];

  // data phase control
  assign pend_o      = (state_q == ssc_pkg::SSC_DATA);
  assign wr_o        = pend_o & grant_i & write_q;
  assign rd_o        = pend_o & grant_i & ~write_q;
  assign hreadyout_o = ~pend_o | wr_o;
  assign hresp_o     = `SSC_HRESP_OKAY;
  assign idx_o       = addr_q[`SSC_ADDR_W-1:`SSC_LANE_LSB];
  assign wdata_o     = hwdata_i;

  // byte lanes from size and low address bits
  always_comb begin
    case (size_q)
      3'h0:    be_o = 8'h01 << addr_q[2:0];
      3'h1:    be_o = 8'h03 << {addr_q[2:1], 1'b0};
      3'h2:    be_o = 8'h0F << {addr_q[2], 2'b00};
      default: be_o = 8'hFF;
    endcase
  end

  // address phase capture
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_q  <= '0;
      size_q  <= 3'h0;
      write_q <= 1'b0;
    end else if (accept) begin
      addr_q  <= haddr_i;
      size_q  <= hsize_i;
      write_q <= hwrite_i;
    end
  end

  // transfer sequencing; reads take one registered wait state
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ssc_pkg::SSC_IDLE;
    end else begin
      case (state_q)
        ssc_pkg::SSC_IDLE: begin
          if (accept) state_q <= ssc_pkg::SSC_DATA;
        end
        ssc_pkg::SSC_DATA: begin
          if (wr_o)      state_q <= accept ? ssc_pkg::SSC_DATA : ssc_pkg::SSC_IDLE;
          else if (rd_o) state_q <= ssc_pkg::SSC_RESP;
        end
        ssc_pkg::SSC_RESP: begin
          state_q <= accept ? ssc_pkg::SSC_DATA : ssc_pkg::SSC_IDLE;
        end
        default: state_q <= ssc_pkg::SSC_IDLE;
      endcase
    end
  end
endmodule : ssc_ahb_port
`default_nettype wire

/* src/ssc_params.svh */
// constants for the dual-port shared sram controller
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH
// ******************************
// storage geometry
// ******************************
`define SSC_MEM_BYTES    131072
`define SSC_WORDS        16384
`define SSC_IDX_W        14
`define SSC_ADDR_W       17
`define SSC_DATA_W       64
`define SSC_BE_W         8
`define SSC_LANE_LSB     3
// ******************************
// semaphore sections
// ******************************
`define SSC_SECTIONS     16384
`define SSC_SECT_W       14
// ******************************
// bus and owner encodings
// ******************************
`define SSC_HTRANS_SEQ_BIT 1
`define SSC_HRESP_OKAY   1'h0
`define SSC_OWN_FREE     2'h0
`define SSC_OWN_PORT0    2'h1
`define SSC_OWN_PORT1    2'h2
`endif

/* src/ssc_pkg.sv */
// types for the dual-port shared sram controller
package ssc_pkg;
  typedef enum logic [1:0] {
    SSC_IDLE = 2'h0,
    SSC_DATA = 2'h1,
    SSC_RESP = 2'h2
  } ssc_port_state_e;
  typedef enum logic {
    SSC_PRIO_FIXED = 1'h0,
    SSC_PRIO_RR    = 1'h1
  } ssc_prio_e;
endpackage : ssc_pkg

/* src/ssc_shared_sram.sv */
// dual-port shared sram controller top with arbitration and semaphores
`timescale 1ns/1ps
`default_nettype none
`include "ssc_params.svh"
// How it works
// - 128 KB of storage as 64-bit words, shared by both ports.
// - reads and writes of 8, 16, 32 and 64 bits are served.
// - two independent ahb slave ports each complete their own transfers.
// - different words on both ports are served together with no stall.
// - same word on both ports: one port waits until the other finishes.
// - the waiting port is chosen by fixed or round-robin priority setting.
// - semaphores let a port claim any of 16K sections exclusively.
module ssc_shared_sram (
  // clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   reset_n_i,
  // configuration
  input  wire logic                   prio_rr_i,
  input  wire logic                   fixed_port1_first_i,
  // ahb port 0
  input  wire logic                   p0_hsel_i,
  input  wire logic [`SSC_ADDR_W-1:0] p0_haddr_i,
  input  wire logic [1:0]             p0_htrans_i,
  input  wire logic                   p0_hwrite_i,
  input  wire logic [2:0]             p0_hsize_i,
  input  wire logic                   p0_hready_i,
  input  wire logic [`SSC_DATA_W-1:0] p0_hwdata_i,
  output logic [`SSC_DATA_W-1:0]      p0_hrdata_o,
  output logic                        p0_hreadyout_o,
  output logic                        p0_hresp_o,
  // ahb port 1
  input  wire logic                   p1_hsel_i,
  input  wire logic [`SSC_ADDR_W-1:0] p1_haddr_i,
  input  wire logic [1:0]             p1_htrans_i,
  input  wire logic                   p1_hwrite_i,
  input  wire logic [2:0]             p1_hsize_i,
  input  wire logic                   p1_hready_i,
  input  wire logic [`SSC_DATA_W-1:0] p1_hwdata_i,
  output logic [`SSC_DATA_W-1:0]      p1_hrdata_o,
  output logic                        p1_hreadyout_o,
  output logic                        p1_hresp_o,
  // semaphore requests, one per master
  input  wire logic                   p0_sem_req_i,
  input  wire logic                   p0_sem_claim_i,
  input  wire logic [`SSC_SECT_W-1:0] p0_sem_sect_i,
  output logic                        p0_sem_ack_o,
  output logic                        p0_sem_ok_o,
  input  wire logic                   p1_sem_req_i,
  input  wire logic                   p1_sem_claim_i,
  input  wire logic [`SSC_SECT_W-1:0] p1_sem_sect_i,
  output logic                        p1_sem_ack_o,
  output logic                        p1_sem_ok_o
);
  // ******************************
  // storage and port front ends
  // ******************************
  logic [`SSC_DATA_W-1:0] mem [`SSC_WORDS];
  logic                   pend0, pend1, grant0, grant1;
  logic                   wr0, wr1, rd0, rd1;
  logic [`SSC_IDX_W-1:0]  idx0, idx1;
  logic [`SSC_BE_W-1:0]   be0, be1;
  logic [`SSC_DATA_W-1:0] wd0, wd1;
  logic [`SSC_DATA_W-1:0] rdata0_q, rdata1_q;

  ssc_ahb_port u_port0 (
    .core_clk_i  (core_clk_i),
    .reset_n_i   (reset_n_i),
    .hsel_i      (p0_hsel_i),
    .haddr_i     (p0_haddr_i),
    .htrans_i    (p0_htrans_i),
    .hwrite_i    (p0_hwrite_i),
    .hsize_i     (p0_hsize_i),
    .hready_i    (p0_hready_i),
    .hwdata_i    (p0_hwdata_i),
    .hreadyout_o (p0_hreadyout_o),
    .hresp_o     (p0_hresp_o),
    .pend_o      (pend0),
    .idx_o       (idx0),
    .grant_i     (grant0),
    .wr_o        (wr0),
    .rd_o        (rd0),
    .be_o        (be0),
    .wdata_o     (wd0)
  );

  ssc_ahb_port u_port1 (
    .core_clk_i  (core_clk_i),
    .reset_n_i   (reset_n_i),
    .hsel_i      (p1_hsel_i),
    .haddr_i     (p1_haddr_i),
    .htrans_i    (p1_htrans_i),
    .hwrite_i    (p1_hwrite_i),
    .hsize_i     (p1_hsize_i),
    .hready_i    (p1_hready_i),
    .hwdata_i    (p1_hwdata_i),
    .hreadyout_o (p1_hreadyout_o),
    .hresp_o     (p1_hresp_o),
    .pend_o      (pend1),
    .idx_o       (idx1),
    .grant_i     (grant1),
    .wr_o        (wr1),
    .rd_o        (rd1),
    .be_o        (be1),
    .wdata_o     (wd1)
  );

  // expand byte enables to a bit mask
  function automatic logic [`SSC_DATA_W-1:0] lane_mask(input logic [`SSC_BE_W-1:0] be);
    logic [`SSC_DATA_W-1:0] m;
    m = '0;
    for (int b = 0; b < `SSC_BE_W; b++) begin
      m[b*8 +: 8] = {8{be[b]}};
    end
    return m;
  endfunction : lane_mask

  // ******************************
  // same-word arbitration
  // ******************************
  logic same;
  logic win0;
  logic last_win1_q;

  // conflict only when both data phases hit one word
  assign same   = pend0 & pend1 & (idx0 == idx1);
  // round robin favours the port that lost last time
  assign win0   = prio_rr_i ? last_win1_q : ~fixed_port1_first_i;
  assign grant0 = pend0 & (~same | win0);
  assign grant1 = pend1 & (~same | ~win0);

  // remember the winner of each conflict
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_win1_q <= 1'b1;
    end else if (same) begin
      last_win1_q <= ~win0;
    end
  end

  // byte-lane writes from both ports
  always_ff @(posedge core_clk_i) begin
    for (int b = 0; b < `SSC_BE_W; b++) begin
      if (wr0 && be0[b]) mem[idx0][b*8 +: 8] <= wd0[b*8 +: 8];
      if (wr1 && be1[b]) mem[idx1][b*8 +: 8] <= wd1[b*8 +: 8];
    end
  end

  // registered read data per port
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata0_q <= '0;
      rdata1_q <= '0;
    end else begin
      if (rd0) rdata0_q <= mem[idx0];
      if (rd1) rdata1_q <= mem[idx1];
    end
  end

  assign p0_hrdata_o = rdata0_q;
  assign p1_hrdata_o = rdata1_q;

  // ******************************
  // section semaphores
  // ******************************
  logic [1:0] owner_q [`SSC_SECTIONS];
  logic       s0_ok, s1_ok;

  // port 0 wins a simultaneous claim of one free section
  assign s0_ok = p0_sem_req_i & (p0_sem_claim_i ? (owner_q[p0_sem_sect_i] == `SSC_OWN_FREE)
                                                : (owner_q[p0_sem_sect_i] == `SSC_OWN_PORT0));
  assign s1_ok = p1_sem_req_i & (p1_sem_claim_i ? (owner_q[p1_sem_sect_i] == `SSC_OWN_FREE)
                                                : (owner_q[p1_sem_sect_i] == `SSC_OWN_PORT1))
               & ~(s0_ok & p0_sem_claim_i & p1_sem_claim_i & (p0_sem_sect_i == p1_sem_sect_i));

  // owner table update
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int s = 0; s < `SSC_SECTIONS; s++) begin
        owner_q[s] <= `SSC_OWN_FREE;
      end
    end else begin
      if (s0_ok) owner_q[p0_sem_sect_i] <= p0_sem_claim_i ? `SSC_OWN_PORT0 : `SSC_OWN_FREE;
      if (s1_ok) owner_q[p1_sem_sect_i] <= p1_sem_claim_i ? `SSC_OWN_PORT1 : `SSC_OWN_FREE;
    end
  end

  // semaphore answers, one cycle after the request
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      p0_sem_ack_o <= 1'b0;
      p0_sem_ok_o  <= 1'b0;
      p1_sem_ack_o <= 1'b0;
      p1_sem_ok_o  <= 1'b0;
    end else begin
      p0_sem_ack_o <= p0_sem_req_i;
      p0_sem_ok_o  <= s0_ok;
      p1_sem_ack_o <= p1_sem_req_i;
      p1_sem_ok_o  <= s1_ok;
    end
  end

  // ******************************
  // checks
  // ******************************
  same_word_excl_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    same |-> !(grant0 && grant1)) else $error("both ports granted on one word");

  diff_word_free_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (pend0 && pend1 && idx0 != idx1) |-> (grant0 && grant1 && p0_hreadyout_o == wr0))
    else $error("port stalled on distinct words");

  rr_loser_served_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (prio_rr_i && pend1 && !grant1) |-> ##[1:2] grant1) else $error("port 1 starved");

  rr_alternate_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (prio_rr_i && same ##1 prio_rr_i && same) |-> (grant0 != $past(grant0)))
    else $error("round robin did not alternate");

  fixed_winner_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (!prio_rr_i && same) |-> (grant1 == fixed_port1_first_i)) else $error("fixed priority broken");

  read_data_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    rd0 |=> (p0_hreadyout_o && p0_hrdata_o == $past(mem[idx0]))) else $error("bad read answer");

  write_lanes_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (wr0 && !(wr1 && idx1 == idx0)) |=>
      ((mem[$past(idx0)] & lane_mask($past(be0))) == ($past(wd0) & lane_mask($past(be0))))
      && ((mem[$past(idx0)] & ~lane_mask($past(be0))) == ($past(mem[idx0]) & ~lane_mask($past(be0)))))
    else $error("narrow write touched wrong bytes");

  sem_owner_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (p0_sem_req_i && p0_sem_claim_i && s0_ok) |=>
      (p0_sem_ok_o && owner_q[$past(p0_sem_sect_i)] == `SSC_OWN_PORT0))
    else $error("claim did not take section");
endmodule : ssc_shared_sram
`default_nettype wire

/* tb/ssc_ahb_master.sv */
// ahb master model driving one port of the shared sram controller
`timescale 1ns/1ps
`default_nettype none
`include "ssc_params.svh"
module ssc_ahb_master (
  // clock
  input  wire logic                   core_clk_i,
  // ahb master side
  output logic                        hsel_o,
  output logic [`SSC_ADDR_W-1:0]      haddr_o,
  output logic [1:0]                  htrans_o,
  output logic                        hwrite_o,
  output logic [2:0]                  hsize_o,
  output logic [`SSC_DATA_W-1:0]      hwdata_o,
  input  wire logic                   hready_i,
  input  wire logic [`SSC_DATA_W-1:0] hrdata_i
);
  // idle bus at time zero
  initial begin
    hsel_o = 1'b0;
    haddr_o = '0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h0;
    hwdata_o = '0;
  end
  // one single transfer, waits counts stalled data cycles, 99 on a hang
  task automatic xfer(input logic w, input logic [`SSC_ADDR_W-1:0] a, input logic [2:0] sz,
      input logic [`SSC_DATA_W-1:0] wd, output logic [`SSC_DATA_W-1:0] rd, output int waits);
    int i;
    @(negedge core_clk_i);
    hsel_o <= 1'b1;
    htrans_o <= 2'h2;
    hwrite_o <= w;
    haddr_o <= a;
    hsize_o <= sz;
    @(negedge core_clk_i);
    // released address lines show a changed pattern, not the old value
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    haddr_o <= ~a;
    hwdata_o <= w ? wd : ~hwdata_o;
    waits = 99;
    for (i = 0; i < 50 && waits == 99; i++) begin
      if (hready_i === 1'b1) waits = i;
      else @(negedge core_clk_i);
    end
    rd = hrdata_i;
  endtask : xfer
  // two pipelined writes, second address taken in the first data phase
  task automatic wr2(input logic [`SSC_ADDR_W-1:0] a0, a1,
      input logic [`SSC_DATA_W-1:0] d0, d1, output int waits);
    int i;
    int w1;
    @(negedge core_clk_i);
    hsel_o <= 1'b1;
    htrans_o <= 2'h2;
    hwrite_o <= 1'b1;
    haddr_o <= a0;
    hsize_o <= 3'h3;
    @(negedge core_clk_i);
    // second address and first data stand until ready is seen
    htrans_o <= 2'h3;
    haddr_o <= a1;
    hwdata_o <= d0;
    waits = 99;
    for (i = 0; i < 50 && waits == 99; i++) begin
      if (hready_i === 1'b1) waits = i;
      else @(negedge core_clk_i);
    end
    @(negedge core_clk_i);
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    haddr_o <= ~a1;
    hwdata_o <= d1;
    w1 = 99;
    for (i = 0; i < 50 && w1 == 99; i++) begin
      if (hready_i === 1'b1) w1 = i;
      else @(negedge core_clk_i);
    end
    waits = (waits == 99 || w1 == 99) ? 99 : waits + w1;
  endtask : wr2
endmodule : ssc_ahb_master
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the dual-port shared sram controller
`timescale 1ns/1ps
`default_nettype none
`include "ssc_params.svh"
module tb;
  // ****************
  // clock, reset and wiring
  // ****************
  logic             core_clk_i = 1'b0;
  logic             reset_n_i = 1'b0;
  logic             prio_rr_i = 1'b0;
  logic             fix1_q = 1'b0;
  logic             sreq [2] = '{2{1'b0}};
  logic             sclm [2] = '{2{1'b0}};
  logic [13:0]      ssect [2] = '{2{14'h0000}};
  wire logic        hsel [2];
  wire logic [16:0] haddr [2];
  wire logic [1:0]  htrans [2];
  wire logic        hwrite [2];
  wire logic [2:0]  hsize [2];
  wire logic [63:0] hwdata [2];
  wire logic [63:0] hrdata [2];
  wire logic        hrdy [2];
  wire logic        hresp [2];
  wire logic        sack [2];
  wire logic        sok [2];
  int               n_mismatch = 0;
  int               comparisons = 0;
  logic [63:0]      mdl;
  always #12.5 core_clk_i = ~core_clk_i;
  for (genvar g = 0; g < 2; g++) begin : gm
    ssc_ahb_master ssc_ahb_master_inst (.core_clk_i(core_clk_i), .hsel_o(hsel[g]),
      .haddr_o(haddr[g]), .htrans_o(htrans[g]), .hwrite_o(hwrite[g]), .hsize_o(hsize[g]),
      .hwdata_o(hwdata[g]), .hready_i(hrdy[g]), .hrdata_i(hrdata[g]));
  end
  ssc_shared_sram ssc_shared_sram_inst (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .prio_rr_i(prio_rr_i), .fixed_port1_first_i(fix1_q),
    .p0_hsel_i(hsel[0]), .p0_haddr_i(haddr[0]), .p0_htrans_i(htrans[0]),
    .p0_hwrite_i(hwrite[0]), .p0_hsize_i(hsize[0]), .p0_hready_i(hrdy[0]),
    .p0_hwdata_i(hwdata[0]), .p0_hrdata_o(hrdata[0]), .p0_hreadyout_o(hrdy[0]),
    .p0_hresp_o(hresp[0]), .p1_hsel_i(hsel[1]), .p1_haddr_i(haddr[1]),
    .p1_htrans_i(htrans[1]), .p1_hwrite_i(hwrite[1]), .p1_hsize_i(hsize[1]),
    .p1_hready_i(hrdy[1]), .p1_hwdata_i(hwdata[1]), .p1_hrdata_o(hrdata[1]),
    .p1_hreadyout_o(hrdy[1]), .p1_hresp_o(hresp[1]),
    .p0_sem_req_i(sreq[0]), .p0_sem_claim_i(sclm[0]), .p0_sem_sect_i(ssect[0]),
    .p0_sem_ack_o(sack[0]), .p0_sem_ok_o(sok[0]), .p1_sem_req_i(sreq[1]),
    .p1_sem_claim_i(sclm[1]), .p1_sem_sect_i(ssect[1]), .p1_sem_ack_o(sack[1]),
    .p1_sem_ok_o(sok[1]));
  // ****************
  // shared tasks
  // ****************
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // one transfer on port p, judged on wait count, response and read data
  task automatic xf(input int p, input logic w, input logic [16:0] a, input logic [2:0] sz,
      input logic [63:0] wd, input int ew, input logic [63:0] ed);
    logic [63:0] rd;
    int          nw;
    if (p == 0) gm[0].ssc_ahb_master_inst.xfer(w, a, sz, wd, rd, nw);
    else gm[1].ssc_ahb_master_inst.xfer(w, a, sz, wd, rd, nw);
    if (nw == 99) begin
      n_mismatch++;
      give_verdict();
    end
    check("waits", 64'(ew), 64'(nw));
    check("hresp", 64'h0, 64'(hresp[p]));
    if (!w) check("hrdata", ed, rd);
  endtask : xf
  // semaphore requests on both ports in one cycle, answer one cycle later
  task automatic sem(input logic r0, c0, input logic [13:0] s0, input logic e0,
      input logic r1, c1, input logic [13:0] s1, input logic e1);
    @(negedge core_clk_i);
    sreq <= '{r0, r1};
    sclm <= '{c0, c1};
    ssect <= '{s0, s1};
    @(negedge core_clk_i);
    sreq <= '{1'b0, 1'b0};
    ssect <= '{~s0, ~s1};
    check("sem_ack0", 64'(r0), 64'(sack[0]));
    check("sem_ack1", 64'(r1), 64'(sack[1]));
    if (r0) check("sem_ok0", 64'(e0), 64'(sok[0]));
    if (r1) check("sem_ok1", 64'(e1), 64'(sok[1]));
  endtask : sem
  task automatic do_reset(input int n);
    @(negedge core_clk_i);
    reset_n_i <= 1'b0;
    repeat (n) @(negedge core_clk_i);
    reset_n_i <= 1'b1;
  endtask : do_reset
  // ****************
  // scenarios
  // ****************
  task automatic t_edges();
    xf(0, 1, 17'h1FFF8, 3, 64'hA5A5_0F0F_1234_5678, 0, 0);
    xf(1, 1, 17'h00000, 3, 64'h0102_0304_0506_0708, 0, 0);
    xf(1, 0, 17'h1FFF8, 3, 0, 1, 64'hA5A5_0F0F_1234_5678);
    xf(0, 0, 17'h00000, 3, 0, 1, 64'h0102_0304_0506_0708);
  endtask : t_edges
  task automatic t_narrow();
    logic [2:0]  a [6] = '{3'h3, 3'h6, 3'h0, 3'h4, 3'h1, 3'h7};
    logic [2:0]  s [6] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h0, 3'h0};
    logic [63:0] wd;
    int          n;
    mdl = 64'h1122_3344_5566_7788;
    xf(0, 1, 17'h00100, 3, mdl, 0, 0);
    for (int i = 0; i < 6; i++) begin
      wd = {8{8'(8'hC0 + i)}};
      n = 1 << s[i];
      for (int b = 0; b < 8; b++)
        if (b >= (a[i] & ~(n - 1)) && b < (a[i] & ~(n - 1)) + n) mdl[8*b+:8] = wd[8*b+:8];
      xf(1, 1, {14'h0020, a[i]}, s[i], wd, 0, 0);
      xf(0, 0, 17'h00100, 3, 0, 1, mdl);
    end
  endtask : t_narrow
  task automatic t_conc();
    fork
      xf(0, 1, 17'h00200, 3, 64'hDEAD_0000_0000_0001, 0, 0);
      xf(1, 1, 17'h00208, 3, 64'hBEEF_0000_0000_0002, 0, 0);
    join
    fork
      xf(0, 0, 17'h00208, 3, 0, 1, 64'hBEEF_0000_0000_0002);
      xf(1, 0, 17'h00200, 3, 0, 1, 64'hDEAD_0000_0000_0001);
    join
  endtask : t_conc
  task automatic t_pipe();
    int nw;
    gm[0].ssc_ahb_master_inst.wr2(17'h00400, 17'h00408, 64'h0000_1111_2222_3333,
      64'h4444_5555_6666_7777, nw);
    if (nw == 99) begin
      n_mismatch++;
      give_verdict();
    end
    check("pipe_waits", 64'h0, 64'(nw));
    xf(1, 0, 17'h00400, 3, 0, 1, 64'h0000_1111_2222_3333);
    xf(1, 0, 17'h00408, 3, 0, 1, 64'h4444_5555_6666_7777);
  endtask : t_pipe
  task automatic t_fixed();
    for (int f = 0; f < 2; f++) begin
      @(negedge core_clk_i);
      prio_rr_i <= 1'b0;
      fix1_q <= f[0];
      fork
        xf(0, 1, 17'h00300, 3, 64'h0, f, 0);
        xf(1, 1, 17'h00300, 3, 64'h1, 1 - f, 0);
      join
      xf(0, 0, 17'h00300, 3, 0, 1, 64'(1 - f));
    end
  endtask : t_fixed
  task automatic t_rr();
    do_reset(3);
    @(negedge core_clk_i);
    prio_rr_i <= 1'b1;
    fork
      xf(0, 0, 17'h00300, 3, 0, 1, 64'h0);
      xf(1, 0, 17'h00300, 3, 0, 2, 64'h0);
    join
    fork
      xf(0, 1, 17'h00300, 3, 64'h5, 1, 0);
      xf(1, 1, 17'h00300, 3, 64'h6, 0, 0);
    join
    xf(1, 0, 17'h00300, 3, 0, 1, 64'h5);
  endtask : t_rr
  task automatic t_sem();
    sem(1, 1, 14'h0005, 1, 0, 0, 0, 0);
    sem(0, 0, 0, 0, 1, 1, 14'h0005, 0);
    sem(1, 1, 14'h3FFF, 1, 1, 0, 14'h0005, 0);
    sem(1, 0, 14'h0005, 1, 1, 0, 14'h3FFF, 0);
    sem(1, 0, 14'h3FFF, 1, 0, 0, 0, 0);
    sem(1, 1, 14'h2000, 1, 1, 1, 14'h2000, 0);
    sem(0, 0, 0, 0, 1, 1, 14'h0005, 1);
  endtask : t_sem
  // main sequence
  initial begin
    repeat (20) @(negedge core_clk_i);
    reset_n_i <= 1'b1;
    t_edges();
    t_narrow();
    t_conc();
    t_pipe();
    t_fixed();
    t_rr();
    t_sem();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
